/* File: hbd_defines.svh */
// Constants for the half-bridge drive control block
`ifndef HBD_DEFINES_SVH
`define HBD_DEFINES_SVH
`define HBD_ID_PART_MSB     11
`define HBD_ID_PART_LSB     9
`define HBD_ID_GEN_MSB      8
`define HBD_ID_GEN_LSB      6
`define HBD_ID_SREV_MSB     5
`define HBD_ID_SREV_LSB     3
`define HBD_ID_MREV_MSB     2
`define HBD_ID_MREV_LSB     0
`define HBD_ID_PART_DEF     3'h5
`define HBD_ID_GEN_DEF      3'h1
`define HBD_ID_SREV_DEF     3'h0
`define HBD_ID_MREV_DEF     3'h0
`define HBD_TEST_WORD_DEF   12'hA5A
`define HBD_CTRL_RST        6'h00
`define HBD_SRC_RST         12'h000
`endif

/* File: hbd_pkg.sv */
// Types shared by the half-bridge drive control block
package hbd_pkg;
    typedef enum logic [1:0] {
        HBD_GATE_OFF  = 2'b00,
        HBD_GATE_LOW  = 2'b01,
        HBD_GATE_HIGH = 2'b10
    } hbd_gate_type;
    typedef enum logic [1:0] {
        HBD_PWR_RESET   = 2'b00,
        HBD_PWR_REDUCED = 2'b01,
        HBD_PWR_FULL    = 2'b10
    } hbd_pwr_type;
endpackage

/* File: hbd_core.sv */
// Half-bridge gate drive control and identification status word
`timescale 1ns/100ps
`include "hbd_defines.svh"
module hbd_core #(
    parameter int          NUM_BRIDGES = 6,
    parameter int          NUM_PWM     = 4,
    // Arbitrary identity fields, not tied to any product
    parameter logic [2:0]  ID_PART     = `HBD_ID_PART_DEF,
    parameter logic [2:0]  ID_GEN      = `HBD_ID_GEN_DEF,
    parameter logic [2:0]  ID_SREV     = `HBD_ID_SREV_DEF,
    parameter logic [2:0]  ID_MREV     = `HBD_ID_MREV_DEF,
    parameter logic [11:0] TEST_WORD   = `HBD_TEST_WORD_DEF
) (
    // Clock and reset
    input  wire logic                     clk_sys_i,
    input  wire logic                     rstn_i,
    // Staged settings from the serial decoder
    input  wire logic [NUM_BRIDGES-1:0]   enable_control_word_i,
    input  wire logic [NUM_BRIDGES-1:0]   polarity_control_word_i,
    input  wire logic [NUM_BRIDGES-1:0]   pulse_mode_control_word_i,
    input  wire logic [2*NUM_BRIDGES-1:0] pulse_source_control_word_i,
    input  wire logic                     driver_power_enable_i,
    input  wire logic                     test_mode_flag_i,
    input  wire logic                     sleep_i,
    // Serial chip select pin
    input  wire logic                     serial_chip_select_i,
    // PWM pins and output comparators
    input  wire logic [NUM_PWM-1:0]       pwm_i,
    input  wire logic [NUM_BRIDGES-1:0]   output_above_thr_i,
    // Gate control and pull-downs
    output logic [NUM_BRIDGES-1:0]        high_side_gate_output_o,
    output logic [NUM_BRIDGES-1:0]        low_side_gate_output_o,
    output logic [NUM_BRIDGES-1:0]        gate_pulldown_o,
    output logic                          charge_pump_en_o,
    output hbd_pkg::hbd_pwr_type          pwr_state_o,
    // Status words
    output logic [11:0]                   identification_status_word_o,
    output logic [11:0]                   output_level_status_word_o
);
    import hbd_pkg::*;

    // Identification value; a silicon bump restarts mask at zero
    localparam logic [11:0] ID_WORD = {ID_PART, ID_GEN, ID_SREV, ID_MREV};

    logic [1:0]               rst_sync_q;
    logic                     rst_n;
    logic [2:0]               cs_sync_q;
    logic                     cs_rise;
    logic [NUM_PWM-1:0]       pwm_s1_q;
    logic [NUM_PWM-1:0]       pwm_s2_q;
    logic [NUM_BRIDGES-1:0]   lvl_s1_q;
    logic [NUM_BRIDGES-1:0]   lvl_s2_q;
    logic [3:0]               ctl_s1_q;
    logic [3:0]               ctl_s2_q;
    logic [NUM_BRIDGES-1:0]   en_q;
    logic [NUM_BRIDGES-1:0]   pol_q;
    logic [NUM_BRIDGES-1:0]   pm_q;
    logic [2*NUM_BRIDGES-1:0] src_q;
    hbd_pwr_type              pwr_q;
    logic [NUM_BRIDGES-1:0]   hs_d;
    logic [NUM_BRIDGES-1:0]   ls_d;
    logic [NUM_BRIDGES-1:0]   hs_q;
    logic [NUM_BRIDGES-1:0]   ls_q;
    logic [NUM_BRIDGES-1:0]   pd_q;
    logic [11:0]              id_q;
    logic [11:0]              lvl_q;

    // Selected PWM level for one bridge; sharing is allowed
    function automatic logic pick_pwm(input logic [NUM_PWM-1:0] p,
                                      input logic [1:0] sel);
        pick_pwm = p[sel];
    endfunction

    // Silicon revision code as a letter; code 0 reads as A
    function automatic logic [7:0] srev_letter(input logic [2:0] code);
        srev_letter = 8'h41 + {5'h00, code};
    endfunction

    // Mask revision code as a level digit; code 0 reads as 0
    function automatic logic [7:0] mrev_digit(input logic [2:0] code);
        mrev_digit = 8'h30 + {5'h00, code};
    endfunction

    // Reset release through two flops
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync_q <= 3'h7;
            pwm_s1_q  <= '0;
            pwm_s2_q  <= '0;
            lvl_s1_q  <= '0;
            lvl_s2_q  <= '0;
        end else begin
            cs_sync_q <= {cs_sync_q[1:0], serial_chip_select_i};
            pwm_s1_q  <= pwm_i;
            pwm_s2_q  <= pwm_s1_q;
            lvl_s1_q  <= output_above_thr_i;
            lvl_s2_q  <= lvl_s1_q;
        end
    end
    // Edge taken between synchronised stages only
    assign cs_rise = cs_sync_q[1] & ~cs_sync_q[2];

    // Loose control levels from another domain, double flopped
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            ctl_s1_q <= 4'h0;
            ctl_s2_q <= 4'h0;
        end else begin
            ctl_s1_q <= {sleep_i, test_mode_flag_i,
                         driver_power_enable_i, 1'b0};
            ctl_s2_q <= ctl_s1_q;
        end
    end

    // Settings latch on chip-select rise, not on PWM edges
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            en_q  <= `HBD_CTRL_RST;
            pol_q <= `HBD_CTRL_RST;
            pm_q  <= `HBD_CTRL_RST;
            src_q <= `HBD_SRC_RST;
        end else if (cs_rise) begin
            en_q  <= enable_control_word_i;
            pol_q <= polarity_control_word_i;
            pm_q  <= pulse_mode_control_word_i;
            src_q <= pulse_source_control_word_i;
        end
    end

    // Power state: reduced until enable set, back on clear or sleep
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            pwr_q <= HBD_PWR_RESET;
        end else if (ctl_s2_q[3] || !ctl_s2_q[1]) begin
            pwr_q <= HBD_PWR_REDUCED;
        end else begin
            pwr_q <= HBD_PWR_FULL;
        end
    end

    // Gate decision per bridge
    always_comb begin
        hs_d = '0;
        ls_d = '0;
        for (int b = 0; b < NUM_BRIDGES; b++) begin
            logic on;
            on = 1'b0;
            // Static mode keeps the chosen side on
            on = pm_q[b] ? pick_pwm(pwm_s2_q, src_q[2*b +: 2]) : 1'b1;
            if (en_q[b] && pwr_q == HBD_PWR_FULL) begin
                // Active side follows level, complement the reverse
                hs_d[b] = pol_q[b] ? on : (pm_q[b] & ~on);
                ls_d[b] = pol_q[b] ? (pm_q[b] & ~on) : on;
            end
        end
    end

    // Registered gate outputs; a cycle of lag hides decode glitches
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            hs_q <= '0;
            ls_q <= '0;
            pd_q <= '1;
        end else begin
            hs_q <= hs_d;
            ls_q <= ls_d;
            pd_q <= {NUM_BRIDGES{pwr_q != HBD_PWR_FULL}};
        end
    end

    // Status words: id or test format, output levels
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            id_q  <= ID_WORD;
            lvl_q <= 12'h000;
        end else begin
            // Fields fixed per die; mask field zero on each new die
            id_q <= ctl_s2_q[2] ? TEST_WORD
                  : {ID_PART, ID_GEN, ID_SREV, ID_MREV};
            lvl_q <= {{(12-NUM_BRIDGES){1'b0}}, lvl_s2_q};
        end
    end

    // Silicon code 0..7 reads as A..H, mask code 0..7 as level 0..7
    assign identification_status_word_o = id_q;
    assign output_level_status_word_o   = lvl_q;
    assign high_side_gate_output_o      = hs_q;
    assign low_side_gate_output_o       = ls_q;
    assign gate_pulldown_o              = pd_q;
    assign charge_pump_en_o             = (pwr_q == HBD_PWR_FULL);
    assign pwr_state_o                  = pwr_q;

    // Never both gates of one bridge on
    a_no_shoot: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        (hs_q & ls_q) == '0)
        else $error("both gates on");
    // Bridge 0 disabled in full power keeps both gates off
    a_en_off: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        $past(pwr_q) == HBD_PWR_FULL && !$past(en_q[0])
        |-> !hs_q[0] && !ls_q[0])
        else $error("disabled bridge on");
    // Pull-downs on and gates off whenever power is not full
    a_pd_reduced: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        pwr_q != HBD_PWR_FULL |=> pd_q == '1 && hs_q == '0 && ls_q == '0)
        else $error("gates not pulled down");
    // Enable without sleep reaches full power one edge later
    a_pwr_up: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        ctl_s2_q[1] && !ctl_s2_q[3] |=> pwr_q == HBD_PWR_FULL)
        else $error("full power not reached");
    // No full power while the enable is clear
    a_pwr_down: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        !ctl_s2_q[1] |=> pwr_q != HBD_PWR_FULL)
        else $error("full power without enable");
    // Pulse settings move only on a chip-select rise
    a_cs_latch: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        !cs_rise |=> $stable(pm_q) && $stable(src_q))
        else $error("setting moved off chip-select edge");
    // Static high side stays on
    a_static_on: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        pwr_q == HBD_PWR_FULL && en_q[0] && !pm_q[0] && pol_q[0]
        |=> hs_q[0])
        else $error("static high side off");
    // Low-side pulse follows the selected synchronised input
    a_pwm_follow: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        pwr_q == HBD_PWR_FULL && en_q[0] && pm_q[0] && !pol_q[0]
        |=> ls_q[0] == $past(pwm_s2_q[src_q[1:0]]))
        else $error("pwm not followed");
    // Test flag clear shows the identification value
    a_id_word: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        !ctl_s2_q[2] |=> identification_status_word_o ==
        {ID_PART, ID_GEN, ID_SREV, ID_MREV})
        else $error("id word wrong");
    // Test flag set shows the factory format
    a_test_word: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        ctl_s2_q[2] |=> identification_status_word_o == TEST_WORD)
        else $error("test word wrong");
    // Level bits track the synchronised comparators
    a_lvl_bits: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        ##1 output_level_status_word_o[NUM_BRIDGES-1:0] == $past(lvl_s2_q))
        else $error("level bits wrong");
    // Id word already holds the value as internal reset lifts
    a_id_reset: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        $rose(rst_n) |-> identification_status_word_o == ID_WORD)
        else $error("id word missing after reset");
    // Each field sits at its own position in the word
    a_id_fields: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        !ctl_s2_q[2] |=>
        identification_status_word_o[`HBD_ID_PART_MSB:`HBD_ID_PART_LSB]
            == ID_PART &&
        identification_status_word_o[`HBD_ID_GEN_MSB:`HBD_ID_GEN_LSB]
            == ID_GEN &&
        identification_status_word_o[`HBD_ID_SREV_MSB:`HBD_ID_SREV_LSB]
            == ID_SREV &&
        identification_status_word_o[`HBD_ID_MREV_MSB:`HBD_ID_MREV_LSB]
            == ID_MREV)
        else $error("id field misplaced");
    // Revision codes decode inside letters A-H and levels 0-7
    a_rev_codes: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        !ctl_s2_q[2] |=>
        srev_letter(id_q[5:3]) inside {[8'h41:8'h48]} &&
        mrev_digit(id_q[2:0]) inside {[8'h30:8'h37]})
        else $error("revision code out of range");
    // Reset leads into the reduced power state first
    a_reset_pwr: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        $rose(rst_n) |=> pwr_q == HBD_PWR_REDUCED)
        else $error("reduced power skipped");
    // Full power releases the pull-downs
    a_pd_full: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        pwr_q == HBD_PWR_FULL |=> pd_q == '0)
        else $error("pull-downs held in full power");
    // Sleep pulls every gate down two edges later
    a_sleep_off: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        ctl_s2_q[3] |=> ##1 pd_q == '1 && hs_q == '0)
        else $error("sleep left gates on");
    // No gate on for any disabled bridge
    a_en_all: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        ((hs_q | ls_q) & ~$past(en_q)) == '0)
        else $error("disabled bridge driven");
    // Polarity zero in static mode turns the low side on
    a_static_low: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        pwr_q == HBD_PWR_FULL && en_q[0] && !pm_q[0] && !pol_q[0]
        |=> ls_q[0] && !hs_q[0])
        else $error("static low side wrong");
    // High-side pulse on with input high, complement opposite
    a_pwm_high: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        pwr_q == HBD_PWR_FULL && en_q[0] && pm_q[0] && pol_q[0]
        |=> hs_q[0] == $past(pwm_s2_q[src_q[1:0]]) &&
        ls_q[0] == !$past(pwm_s2_q[src_q[1:0]]))
        else $error("high side pulse wrong");
    // Two bridges on one source switch together
    a_shared_src: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        pwr_q == HBD_PWR_FULL && en_q[1:0] == 2'h3 &&
        pm_q[1:0] == 2'h3 && pol_q[1] == pol_q[0] &&
        src_q[3:2] == src_q[1:0]
        |=> hs_q[1] == hs_q[0] && ls_q[1] == ls_q[0])
        else $error("shared source diverged");

    // Main scenarios
    c_full_pwr: cover property (@(posedge clk_sys_i)
        pwr_q == HBD_PWR_REDUCED ##1 pwr_q == HBD_PWR_FULL);
    c_pwm_high: cover property (@(posedge clk_sys_i)
        pm_q[0] && pol_q[0] && hs_q[0] ##1 !hs_q[0]);
    c_shared: cover property (@(posedge clk_sys_i)
        pm_q[1:0] == 2'h3 && src_q[1:0] == src_q[3:2] && ls_q[1:0] == 2'h3);
    c_test: cover property (@(posedge clk_sys_i)
        identification_status_word_o == TEST_WORD);
    c_sleep: cover property (@(posedge clk_sys_i)
        pwr_q == HBD_PWR_FULL ##1 ctl_s2_q[3]);
endmodule

/* File: hbd_host_model.sv */
// Host-side model: staged serial settings, chip select, PWM pins
`timescale 1ns/100ps
module hbd_host_model #(
    parameter int STAGGER = 3
) (
    // Clock
    input  wire logic   clk_sys_i,
    // Staged settings and chip select
    output logic [5:0]  enable_control_word_o,
    output logic [5:0]  polarity_control_word_o,
    output logic [5:0]  pulse_mode_control_word_o,
    output logic [11:0] pulse_source_control_word_o,
    output logic        serial_chip_select_o,
    // PWM pins
    output logic [3:0]  pwm_o
);
    // Idle host: deselected with chip select high, words and PWM pins low
    initial begin
        {enable_control_word_o, polarity_control_word_o} = 12'h000;
        {pulse_mode_control_word_o, pulse_source_control_word_o} = 18'h00000;
        serial_chip_select_o = 1'h1;
        pwm_o = 4'h0;
    end
    // Words change only while selected
    task automatic stage(input logic [5:0] en, pol, pm,
                         input logic [11:0] src);
        @(negedge clk_sys_i);
        serial_chip_select_o = 1'h0;
        enable_control_word_o = en;
        polarity_control_word_o = pol;
        pulse_mode_control_word_o = pm;
        pulse_source_control_word_o = src;
    endtask
    // Words held stable around the rise so the sync sees them settled
    task automatic strobe();
        repeat (3) @(negedge clk_sys_i);
        serial_chip_select_o = 1'h1;
        repeat (3) @(negedge clk_sys_i);
    endtask
    // Edges of different pins spread apart to spare the overload sense
    task automatic drive_pwm(input logic [3:0] lvl);
        for (int i = 0; i < 4; i++) begin
            if (pwm_o[i] !== lvl[i]) begin
                @(negedge clk_sys_i);
                pwm_o[i] = lvl[i];
                repeat (STAGGER - 1) @(negedge clk_sys_i);
            end
        end
    endtask
endmodule

/* File: half_bridge_drive_control_test.sv */
// Self-checking testbench for the half-bridge drive control block
`timescale 1ns/100ps
`include "hbd_defines.svh"
`define CHK(got, exp) check(12'(got), 12'(exp));
module half_bridge_drive_control_test;
    import hbd_pkg::*;
    logic        clk_sys_i, rstn_i, driver_power_enable, tmode, sleep, cs, cp;
    logic [5:0]  en_w, pol_w, pm_w, thr, hs, ls, pd, c_en, c_pol, c_pm;
    logic [11:0] src_w, c_src, id_w, lvl_w, id_exp;
    logic [3:0]  pwm;
    hbd_pwr_type pwr;
    int          mismatches, compares, k;
    integer      seed;
    hbd_host_model host (.clk_sys_i(clk_sys_i), .enable_control_word_o(en_w),
        .polarity_control_word_o(pol_w), .pulse_mode_control_word_o(pm_w),
        .pulse_source_control_word_o(src_w), .serial_chip_select_o(cs),
        .pwm_o(pwm));
    hbd_core DUT (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .enable_control_word_i(en_w), .polarity_control_word_i(pol_w),
        .pulse_mode_control_word_i(pm_w), .pulse_source_control_word_i(src_w),
        .driver_power_enable_i(driver_power_enable), .test_mode_flag_i(tmode),
        .sleep_i(sleep), .serial_chip_select_i(cs), .pwm_i(pwm),
        .output_above_thr_i(thr), .high_side_gate_output_o(hs),
        .low_side_gate_output_o(ls), .gate_pulldown_o(pd),
        .charge_pump_en_o(cp), .pwr_state_o(pwr),
        .identification_status_word_o(id_w),
        .output_level_status_word_o(lvl_w));
    // 25 MHz system clock
    initial begin
        clk_sys_i = 1'h0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    task automatic check(input logic [11:0] g, e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Gate pair per bridge: active side from polarity, level from source
    function automatic logic [11:0] exp_gates(input logic f,
        input logic [5:0] en, pol, pm, input logic [11:0] s,
        input logic [3:0] p);
        logic [5:0] h, l;
        logic       a, c;
        for (int b = 0; b < 6; b++) begin
            a = pm[b] ? p[s[2*b+:2]] : 1'h1;
            c = pm[b] & ~p[s[2*b+:2]];
            h[b] = f & en[b] & (pol[b] ? a : c);
            l[b] = f & en[b] & (pol[b] ? c : a);
        end
        return {h, l};
    endfunction
    // Covers cs and PWM sync latency with margin
    task automatic settle();
        repeat (6) @(negedge clk_sys_i);
    endtask
    task automatic apply(input logic [5:0] en, pol, pm,
                         input logic [11:0] s, input logic commit);
        host.stage(en, pol, pm, s);
        if (commit) begin
            host.strobe();
            {c_en, c_pol, c_pm, c_src} = {en, pol, pm, s};
        end
        settle();
    endtask
    task automatic verify();
        logic        f;
        logic [11:0] e;
        f = driver_power_enable & ~sleep;
        e = exp_gates(f, c_en, c_pol, c_pm, c_src, pwm);
        `CHK(hs, e[11:6])
        `CHK(ls, e[5:0])
        `CHK(pd, f ? 6'h00 : 6'h3F)
    endtask
    // Hang guard, far beyond the expected run
    initial begin
        #(40 * 8000);
        mismatches++;
        wrap_up();
    end
    initial begin
        {driver_power_enable, tmode, sleep, rstn_i, thr, mismatches, compares} = 0;
        {c_en, c_pol, c_pm, c_src} = 30'h0;
        seed = 21;
        id_exp = {`HBD_ID_PART_DEF, `HBD_ID_GEN_DEF,
                  `HBD_ID_SREV_DEF, `HBD_ID_MREV_DEF};
        repeat (10) @(negedge clk_sys_i);
        `CHK(pd, 6'h3F)
        rstn_i = 1'h1;
        settle();
        `CHK(pwr, HBD_PWR_REDUCED)
        `CHK(cp, 1'h0)
        `CHK(id_w, id_exp)
        apply(6'h3F, 6'h15, 6'h00, 12'h000, 1'h1);
        verify();
        driver_power_enable = 1'h1;
        settle();
        `CHK(pwr, HBD_PWR_FULL)
        `CHK(cp, 1'h1)
        verify();
        tmode = 1'h1;
        settle();
        `CHK(id_w, `HBD_TEST_WORD_DEF)
        tmode = 1'h0;
        settle();
        `CHK(id_w, id_exp)
        // Staged but not committed: outputs must keep old settings
        apply(6'h3F, 6'h2A, 6'h3F, 12'hFFF, 1'h0);
        verify();
        host.strobe();
        {c_en, c_pol, c_pm, c_src} = {6'h3F, 6'h2A, 6'h3F, 12'hFFF};
        settle();
        verify();
        // Each source in turn, shared by all six bridges
        for (k = 0; k < 4; k++) begin
            apply(6'h3F, 6'($random(seed)), 6'h3F, {6{k[1:0]}}, 1'h1);
            host.drive_pwm(4'h1 << k);
            settle();
            verify();
            host.drive_pwm(~(4'h1 << k));
            settle();
            verify();
        end
        for (k = 0; k < 24; k++) begin
            thr = 6'($random(seed));
            apply(6'($random(seed)), 6'($random(seed)), 6'($random(seed)),
                  12'($random(seed)), 1'h1);
            host.drive_pwm(4'($random(seed)));
            settle();
            verify();
            `CHK(lvl_w, {6'h00, thr})
        end
        sleep = 1'h1;
        settle();
        `CHK(pwr, HBD_PWR_REDUCED)
        verify();
        sleep = 1'h0;
        driver_power_enable = 1'h0;
        settle();
        verify();
        wrap_up();
    end
endmodule
